// [rtl/ifc_pkg.sv]
// Constants, register map and carrier types for the force/config/mask-set block
// Functional notes
// RULE_01: Two 32-bit force registers, one bit per source; 1 raises, 0 withdraws.
// RULE_02: A forced request reaches prioritisation whatever the source mask says.
// RULE_03: With hardware masking on, acknowledge loads level; old current goes to saved.
// RULE_04: With hardware masking off, acknowledge leaves current and saved masks unchanged.
// RULE_05: Software saves the saved mask on entry and restores it near exit.
// RULE_06: Configuration bits 4..0 choose which of 16 levels drive the fast output.
// RULE_07: Mask-set write of 0x00..0x3F sets only that source mask bit.
// RULE_08: Mask-set write of 0x40..0x7F sets all 64 source mask bits.
// RULE_09: Mask-set port reads as zero and reading leaves the mask alone.
// RULE_10: Mask bit 1 disables, 0 enables its source; reset sets all to one.
// RULE_11: Same-cycle mask-set and mask-clear writes perform the set only.
// RULE_12: Requests at or below the current level mask cannot raise the interrupt.
// RULE_13: Force bit ORs with hardware request; force bits reset to zero.
`default_nettype none

package ifc_pkg;

  localparam int NUM_SRC = 64;
  localparam int ADDR_W  = 8;
  localparam int LVL_W   = 4;
  localparam int CLM_W   = 5;
  localparam int EVT_W   = 2;

  // Byte offsets
  localparam logic [ADDR_W-1:0] OFS_FORCE_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FORCE_LOW  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONFIG     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK_SET   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_SRC_MASK_L = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_SRC_MASK_H = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 8'h30;

  // Field positions
  localparam int CFG_HW_MASK_BIT = 5;
  localparam int CFG_MAP_LSB     = 0;
  localparam int SET_ALL_BIT     = 6;
  localparam int SET_VAL_W       = 7;
  localparam int LVL_CUR_LSB     = 0;
  localparam int LVL_SAVED_LSB   = 8;
  localparam int EVT_ACK_BIT     = 0;
  localparam int EVT_SET_ALL_BIT = 1;

  // Reset values
  localparam logic [31:0]        FORCE_RST      = 32'h0000_0000;
  localparam logic [5:0]         CONFIG_RST     = 6'h1F;
  localparam logic [CLM_W-1:0]   CUR_LVL_RST    = 5'h1F;
  localparam logic [CLM_W-1:0]   SAVED_LVL_RST  = 5'h1F;
  localparam logic [NUM_SRC-1:0] SRC_MASK_RST   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [EVT_W-1:0]   EVT_ENABLE_RST = 2'h0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } ifc_reg_req_t;

  typedef struct packed {
    logic                 valid;
    logic [SET_VAL_W-1:0] value;
  } ifc_mask_cmd_t;

endpackage : ifc_pkg

`default_nettype wire

// [rtl/ifc_ahb_slave.sv]
// AHB-Lite slave front end turning bus transfers into register strobes
`default_nettype none

module ifc_ahb_slave
  import ifc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  output ifc_reg_req_t      regReq,
  input  wire logic [31:0]  regRdData
);

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ_DONE} ifc_bus_state_t;

  ifc_bus_state_t    state_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              hit_reg;
  logic              accept;

  assign accept = hsel && htrans[1] && hready;

  // Transfer sequencing; reads take one wait state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_READ_WAIT: state_reg <= ST_READ_DONE;
        ST_IDLE, ST_WRITE, ST_READ_DONE: begin
          if (accept) begin
            state_reg <= hwrite ? ST_WRITE : ST_READ_WAIT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Address capture with full decode of upper bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= 8'h00;
      hit_reg  <= 1'b0;
    end else if (accept) begin
      addr_reg <= haddr[ADDR_W-1:0];
      hit_reg  <= (haddr[31:ADDR_W] == 24'h00_0000) && (hsize == 3'h2);
    end
  end

  // Read data held through the final data-phase cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (state_reg == ST_READ_WAIT) begin
      hrdata <= hit_reg ? regRdData : 32'h0000_0000;
    end
  end

  assign hreadyout    = (state_reg != ST_READ_WAIT);
  assign hresp        = 1'b0;
  assign regReq = '{wr:    (state_reg == ST_WRITE) && hit_reg,
                    rd:    (state_reg == ST_READ_WAIT) && hit_reg,
                    addr:  addr_reg,
                    wdata: hwdata};

endmodule : ifc_ahb_slave

`default_nettype wire

// [rtl/ifc_mask_ctrl.sv]
// Force registers, configuration, mask-set port and level masking of the controller
//
// Chosen here: the AHB-Lite slave port.
`default_nettype none

module ifc_mask_ctrl
  import ifc_pkg::*;
#(
  parameter int NSRC = NUM_SRC
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic [NSRC-1:0]       hwRequest,
  input  wire logic [NSRC-1:0][3:0]  srcLevel,
  input  wire logic                  ackValid,
  input  wire logic [LVL_W-1:0]      ackLevel,
  input  wire ifc_mask_cmd_t         maskClearCmd,
  output logic [NSRC-1:0]            sourceRequest,
  output logic [NSRC-1:0]            sourceMask,
  output logic [CLM_W-1:0]           currentLevelMask,
  output logic [CLM_W-1:0]           savedLevelMask,
  output logic                       normalInterruptOutput,
  output logic                       fastInterruptOutput,
  output logic                       eventIrq
);

  if (NSRC != NUM_SRC) begin : g_check
    $error("ifc_mask_ctrl serves exactly 64 sources");
  end

  // Bit selection shared by set and clear ports
  function automatic logic [NUM_SRC-1:0] selectBits(input logic [SET_VAL_W-1:0] v);
    if (v[SET_ALL_BIT]) begin
      selectBits = 64'hFFFF_FFFF_FFFF_FFFF;
    end else begin
      selectBits = 64'h0000_0000_0000_0001 << v[5:0];
    end
  endfunction : selectBits

  // Level strictly above the signed current mask
  function automatic logic levelPasses(input logic [LVL_W-1:0] lvl, input logic [CLM_W-1:0] cur);
    levelPasses = $signed({1'b0, lvl}) > $signed(cur);
  endfunction : levelPasses

  ifc_reg_req_t        regReq;
  logic [31:0]         rdValue;
  logic [NSRC-1:0]     hwMeta_reg;
  logic [NSRC-1:0]     hwSync_reg;
  logic [31:0]         forceLow_reg;
  logic [31:0]         forceHigh_reg;
  logic [5:0]          config_reg;
  logic [NSRC-1:0]     mask_reg;
  logic [NSRC-1:0]     mask_next;
  logic [CLM_W-1:0]    curLvl_reg;
  logic [CLM_W-1:0]    savedLvl_reg;
  logic [EVT_W-1:0]    evtStatus_reg;
  logic [EVT_W-1:0]    evtEnable_reg;
  logic [EVT_W-1:0]    evtSet;
  logic [NSRC-1:0]     reqComb;
  logic [NSRC-1:0]     passLevel;
  logic [NSRC-1:0]     fastSel;
  logic [NSRC-1:0]     forceAll;
  logic                setOp;
  logic                lvlWrite;
  logic                hwMaskOn;
  logic                irqNormal_reg;
  logic                irqFast_reg;
  logic [NSRC-1:0]     req_reg;

  ifc_ahb_slave u_bus (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .regReq    (regReq),
    .regRdData (rdValue)
  );

  assign setOp    = regReq.wr && (regReq.addr == OFS_MASK_SET);
  assign lvlWrite = regReq.wr && (regReq.addr == OFS_LEVEL);
  assign hwMaskOn = config_reg[CFG_HW_MASK_BIT];
  assign forceAll = {forceHigh_reg, forceLow_reg};

  // Request pins from peripherals are synchronised
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hwMeta_reg <= 64'h0000_0000_0000_0000;
      hwSync_reg <= 64'h0000_0000_0000_0000;
    end else begin
      hwMeta_reg <= hwRequest;
      hwSync_reg <= hwMeta_reg;
    end
  end

  // Force registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      forceLow_reg  <= FORCE_RST;                                       // [RULE_13]
      forceHigh_reg <= FORCE_RST;
    end else if (regReq.wr && regReq.addr == OFS_FORCE_LOW) begin
      forceLow_reg  <= regReq.wdata;                                    // [RULE_01]
    end else if (regReq.wr && regReq.addr == OFS_FORCE_HIGH) begin
      forceHigh_reg <= regReq.wdata;                                    // [RULE_01]
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      config_reg <= CONFIG_RST;
    end else if (regReq.wr && regReq.addr == OFS_CONFIG) begin
      config_reg <= regReq.wdata[5:0];
    end
  end

  // Source mask: set port beats clear port
  always_comb begin
    mask_next = mask_reg;
    if (setOp) begin                                                    // [RULE_11]
      mask_next = mask_reg | selectBits(regReq.wdata[SET_VAL_W-1:0]);   // [RULE_07] [RULE_08]
    end else if (maskClearCmd.valid) begin
      mask_next = mask_reg & ~selectBits(maskClearCmd.value);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= SRC_MASK_RST;                                         // [RULE_10]
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Current and saved level masks; acknowledge with hardware masking on wins over software write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      curLvl_reg   <= CUR_LVL_RST;
      savedLvl_reg <= SAVED_LVL_RST;
    end else if (ackValid && hwMaskOn) begin                            // [RULE_04]
      curLvl_reg   <= {1'b0, ackLevel};                                 // [RULE_03]
      savedLvl_reg <= curLvl_reg;                                       // [RULE_03]
    end else if (lvlWrite) begin
      curLvl_reg   <= regReq.wdata[LVL_CUR_LSB +: CLM_W];
      savedLvl_reg <= regReq.wdata[LVL_SAVED_LSB +: CLM_W];
    end
  end

  // Request combine, level gating and fast/normal split
  always_comb begin
    reqComb   = (hwSync_reg & ~mask_reg) | forceAll;                    // [RULE_02] [RULE_13]
    passLevel = '0;
    fastSel   = '0;
    for (int i = 0; i < NSRC; i++) begin
      passLevel[i] = levelPasses(srcLevel[i], curLvl_reg);              // [RULE_12]
      fastSel[i]   = !config_reg[4] && (srcLevel[i] >= config_reg[3:0]);  // [RULE_06]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_reg       <= 64'h0000_0000_0000_0000;
      irqNormal_reg <= 1'b0;
      irqFast_reg   <= 1'b0;
    end else begin
      req_reg       <= reqComb;
      irqNormal_reg <= |(reqComb & passLevel & ~fastSel);               // [RULE_12]
      irqFast_reg   <= |(reqComb & passLevel & fastSel);                // [RULE_06] [RULE_12]
    end
  end

  // Event status, write one to clear; new events win
  assign evtSet[EVT_ACK_BIT]     = ackValid && hwMaskOn;
  assign evtSet[EVT_SET_ALL_BIT] = setOp && regReq.wdata[SET_ALL_BIT];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evtStatus_reg <= 2'h0;
    end else if (regReq.wr && regReq.addr == OFS_EVT_STATUS) begin
      evtStatus_reg <= (evtStatus_reg & ~regReq.wdata[EVT_W-1:0]) | evtSet;
    end else begin
      evtStatus_reg <= evtStatus_reg | evtSet;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evtEnable_reg <= EVT_ENABLE_RST;
    end else if (regReq.wr && regReq.addr == OFS_EVT_ENABLE) begin
      evtEnable_reg <= regReq.wdata[EVT_W-1:0];
    end
  end

  // Readback
  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (regReq.addr)
      OFS_FORCE_LOW:  rdValue = forceLow_reg;
      OFS_FORCE_HIGH: rdValue = forceHigh_reg;
      OFS_CONFIG:     rdValue = {26'h000_0000, config_reg};
      OFS_MASK_SET:   rdValue = 32'h0000_0000;                          // [RULE_09]
      OFS_LEVEL:      rdValue = {19'h0_0000, savedLvl_reg, 3'h0, curLvl_reg};
      OFS_SRC_MASK_L: rdValue = mask_reg[31:0];
      OFS_SRC_MASK_H: rdValue = mask_reg[63:32];
      OFS_EVT_STATUS: rdValue = {30'h0000_0000, evtStatus_reg};
      OFS_EVT_ENABLE: rdValue = {30'h0000_0000, evtEnable_reg};
      default:        rdValue = 32'h0000_0000;
    endcase
  end

  assign sourceRequest         = req_reg;
  assign sourceMask            = mask_reg;
  assign currentLevelMask      = curLvl_reg;
  assign savedLevelMask        = savedLvl_reg;
  assign normalInterruptOutput = irqNormal_reg;
  assign fastInterruptOutput   = irqFast_reg;
  assign eventIrq              = |(evtStatus_reg & evtEnable_reg);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_hw_ack;
    ackValid && hwMaskOn;
  endsequence

  sequence s_level_loaded;
    (curLvl_reg == {1'b0, $past(ackLevel)}) && (savedLvl_reg == $past(curLvl_reg));
  endsequence

  a_force_low_write: assert property (                                   // [RULE_01]
    regReq.wr && regReq.addr == OFS_FORCE_LOW |=> forceLow_reg == $past(regReq.wdata))
    else $error("force low register did not take written value");

  a_force_over_mask: assert property (                                   // [RULE_02]
    (forceAll & mask_reg) != '0 |=>
      (sourceRequest & $past(forceAll & mask_reg)) == $past(forceAll & mask_reg))
    else $error("forced request blocked by source mask");

  a_ack_loads_level: assert property (s_hw_ack |=> s_level_loaded)       // [RULE_03]
    else $error("acknowledge did not load level masks");

  a_ack_no_masking: assert property (                                    // [RULE_04]
    ackValid && !hwMaskOn && !lvlWrite |=> $stable(curLvl_reg) && $stable(savedLvl_reg))
    else $error("level masks changed with hardware masking off");

  a_fast_route: assert property (                                        // [RULE_06]
    (reqComb & passLevel & fastSel) != '0 |=> fastInterruptOutput)
    else $error("fast-mapped request did not raise fast output");

  a_set_one_bit: assert property (                                       // [RULE_07]
    setOp && !regReq.wdata[SET_ALL_BIT] |=>
      mask_reg == ($past(mask_reg) | (64'h0000_0000_0000_0001 << $past(regReq.wdata[5:0]))))
    else $error("mask-set did not set exactly one bit");

  a_set_all_bits: assert property (setOp && regReq.wdata[SET_ALL_BIT] |=> &mask_reg)  // [RULE_08]
    else $error("global mask-set did not set all bits");

  a_set_port_reads: assert property (                                    // [RULE_09]
    regReq.rd && regReq.addr == OFS_MASK_SET && !maskClearCmd.valid |->
      rdValue == 32'h0000_0000 ##1 $stable(mask_reg))
    else $error("mask-set port read not zero or had side effect");

  a_mask_reset: assert property (                                        // [RULE_10]
    @(posedge sys_clk) disable iff (1'b0) !rstn && $past(!rstn) |-> mask_reg == SRC_MASK_RST)
    else $error("source mask not all ones in reset");

  a_set_over_clear: assert property (                                    // [RULE_11]
    setOp && maskClearCmd.valid |=>
      (mask_reg & $past(selectBits(regReq.wdata[SET_VAL_W-1:0])))
        == $past(selectBits(regReq.wdata[SET_VAL_W-1:0])))
    else $error("clear overrode simultaneous set");

  a_level_blocks: assert property (                                      // [RULE_12]
    (reqComb & passLevel) == '0 |=> !normalInterruptOutput && !fastInterruptOutput)
    else $error("interrupt raised by request at or below level mask");

  a_hw_or_force: assert property (                                       // [RULE_13]
    (hwSync_reg & ~mask_reg & ~forceAll) != '0 |=>
      (sourceRequest & $past(hwSync_reg & ~mask_reg)) == $past(hwSync_reg & ~mask_reg))
    else $error("unmasked hardware request lost");

endmodule : ifc_mask_ctrl

`default_nettype wire

// [verification/ifc_core_model.sv]
// Processor core model that acknowledges a raised interrupt on request
`default_nettype none

module ifc_core_model
  import ifc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             irqIn,
  input  wire logic             ackReq,
  input  wire logic [3:0]       ackDelay,
  input  wire logic [LVL_W-1:0] reqLevel,
  output logic                  ackValid,
  output logic [LVL_W-1:0]      ackLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       reqSeen_reg;
  logic       busy_reg;
  logic [3:0] cnt_reg;

  // One acknowledge per rising request, after the given delay
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reqSeen_reg <= 1'b0;
      busy_reg    <= 1'b0;
      cnt_reg     <= 4'h0;
      ackValid    <= 1'b0;
      ackLevel    <= 4'h0;
    end else begin
      reqSeen_reg <= ackReq;
      ackValid    <= 1'b0;
      ackLevel    <= ackLevel + 4'h5;
      if (ackReq && !reqSeen_reg) begin
        busy_reg <= 1'b1;
        cnt_reg  <= ackDelay;
      end else if (busy_reg && irqIn) begin
        if (cnt_reg == 4'h0) begin
          busy_reg <= 1'b0;
          ackValid <= 1'b1;
          ackLevel <= reqLevel;
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
        end
      end
    end
  end

endmodule : ifc_core_model

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the force, configuration and mask-set block
`default_nettype none

module tb_top
  import ifc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ZERO = 32'h0000_0000;

  logic             sys_clk, rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata, rdv;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             ackValid, ackReq, nIrq, fIrq, eventIrq, up, fs;
  logic [3:0]       ackLevel, reqLevel, ackDelay, lv;
  logic [4:0]       curLvl, savLvl, cl, fm;
  logic [63:0]      hwRequest, sourceRequest, sourceMask, mdlMask, mdlForce;
  logic [63:0][3:0] srcLevel;
  ifc_mask_cmd_t    maskClearCmd;
  int               n_fail, checks, seed, idx;
  int               lvlStack[$];

  ifc_mask_ctrl #(.NSRC(64)) u_ifc_mask_ctrl (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .hwRequest(hwRequest), .srcLevel(srcLevel), .ackValid(ackValid),
    .ackLevel(ackLevel), .maskClearCmd(maskClearCmd), .sourceRequest(sourceRequest),
    .sourceMask(sourceMask), .currentLevelMask(curLvl), .savedLevelMask(savLvl),
    .normalInterruptOutput(nIrq), .fastInterruptOutput(fIrq), .eventIrq(eventIrq));

  ifc_core_model u_ifc_core_model (.sys_clk(sys_clk), .rstn(rstn),
    .irqIn(nIrq | fIrq), .ackReq(ackReq), .ackDelay(ackDelay), .reqLevel(reqLevel),
    .ackValid(ackValid), .ackLevel(ackLevel));

  always #5 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Bounded wait for a signal sampled high at a rising edge
  task automatic waitHigh(ref logic s, input string what);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (s !== 1'b1 && n < 40);
    if (s !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t timeout %s", $time, what);
      tally_and_finish();
    end
  endtask : waitHigh

  // Single word transfer; clr is driven alongside the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input ifc_mask_cmd_t clr);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    waitHigh(hreadyout, "addr");
    hsel         <= 1'b0;
    htrans       <= 2'b00;
    hwdata       <= wd;
    maskClearCmd <= clr;
    waitHigh(hreadyout, "data");
    rdv = hrdata;
    maskClearCmd <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, '0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, ZERO, '0);
    chk(rdv, exp, "read");
    chk(hresp, 1'b0, "resp");
  endtask : rd

  task automatic ack(input logic [3:0] l, input logic [3:0] d);
    reqLevel <= l;
    ackDelay <= d;
    ackReq   <= 1'b1;
    waitHigh(ackValid, "ack");
    ackReq <= 1'b0;
  endtask : ack

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = ZERO;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = ZERO;
    hwRequest = '0;
    srcLevel = '0;
    maskClearCmd = '0;
    ackReq = 1'b0;
    reqLevel = 4'h0;
    ackDelay = 4'h0;
    n_fail = 0;
    checks = 0;
    seed = 32'h45cf;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_FORCE_LOW, ZERO);
    rd(OFS_FORCE_HIGH, ZERO);
    rd(OFS_CONFIG, 32'h0000_001F);
    rd(OFS_LEVEL, 32'h0000_1F1F);
    rd(OFS_SRC_MASK_L, 32'hFFFF_FFFF);
    rd(OFS_SRC_MASK_H, 32'hFFFF_FFFF);
    rd(OFS_MASK_SET, ZERO);
    rd(8'h3C, ZERO);
    // Event interrupt raised, masked and cleared
    wr(OFS_EVT_ENABLE, 32'h0000_0002);
    wr(OFS_MASK_SET, 32'h0000_0040);
    tick(2);
    chk(eventIrq, 1'b1, "evt set");
    rd(OFS_EVT_STATUS, 32'h0000_0002);
    wr(OFS_EVT_STATUS, 32'h0000_0002);
    wr(OFS_EVT_ENABLE, 32'h0000_0001);
    wr(OFS_MASK_SET, 32'h0000_007F);
    tick(2);
    chk(eventIrq, 1'b0, "evt masked");
    rd(OFS_EVT_STATUS, 32'h0000_0002);
    wr(OFS_EVT_STATUS, 32'h0000_0002);
    // Force bits past an all-ones mask
    idx = $unsigned($random(seed)) % 32;
    mdlForce = {32'h0000_0001 << idx, 32'h8000_0000 >> idx};
    wr(OFS_FORCE_HIGH, mdlForce[63:32]);
    wr(OFS_FORCE_LOW, mdlForce[31:0]);
    tick(2);
    chk(sourceRequest, mdlForce, "force");
    rd(OFS_FORCE_HIGH, mdlForce[63:32]);
    wr(OFS_FORCE_LOW, ZERO);
    wr(OFS_FORCE_HIGH, ZERO);
    tick(2);
    chk(sourceRequest, '0, "withdraw");
    // Hardware requests, single sets and set against clear
    hwRequest <= {$random(seed), $random(seed)};
    maskClearCmd <= 8'hC0;
    @(posedge sys_clk);
    maskClearCmd <= '0;
    mdlMask = '0;
    tick(4);
    chk(sourceMask, mdlMask, "clear all");
    chk(sourceRequest, hwRequest, "hw req");
    for (int k = 0; k < 6; k++) begin
      idx = $unsigned($random(seed)) % 64;
      mdlMask[idx] = 1'b1;
      bus(1'b1, OFS_MASK_SET, idx, k[0] ? 8'hFF : 8'h00);
      tick(3);
      chk(sourceMask, mdlMask, "set one");
      chk(sourceRequest, hwRequest & ~mdlMask, "masked");
    end
    rd(OFS_MASK_SET, ZERO);
    rd(OFS_SRC_MASK_L, mdlMask[31:0]);
    rd(OFS_SRC_MASK_H, mdlMask[63:32]);
    wr(OFS_FORCE_LOW, 32'hFFFF_FFFF);
    tick(2);
    chk(sourceRequest, (hwRequest & ~mdlMask) | 64'hFFFF_FFFF, "or");
    wr(OFS_MASK_SET, 32'h0000_0040 | ($random(seed) & 32'h0000_003F));
    tick(2);
    chk(sourceMask, '1, "set all");
    hwRequest <= '0;
    // Level masking and fast routing of source 3
    wr(OFS_FORCE_LOW, 32'h0000_0008);
    for (int k = 0; k < 16; k++) begin
      lv = 4'($random(seed));
      cl = 5'($random(seed));
      fm = 5'($random(seed));
      srcLevel[3] <= lv;
      wr(OFS_CONFIG, {27'h000_0000, fm});
      wr(OFS_LEVEL, {19'h0_0000, cl, 3'h0, cl});
      tick(3);
      up = $signed({1'b0, lv}) > $signed(cl);
      fs = up && fm < 16 && lv >= fm;
      chk(fIrq, fs, "fast");
      chk(nIrq, up && !fs, "normal");
    end
    // Acknowledge with automatic masking off, then on and nested
    srcLevel[3] <= 4'h7;
    wr(OFS_CONFIG, 32'h0000_001F);
    wr(OFS_LEVEL, 32'h0000_1F1F);
    ack(4'h7, 4'h0);
    tick(2);
    rd(OFS_LEVEL, 32'h0000_1F1F);
    chk(eventIrq, 1'b0, "no ack evt");
    wr(OFS_CONFIG, 32'h0000_003F);
    ack(4'h7, 4'h3);
    tick(3);
    chk({savLvl, curLvl}, 10'h3E7, "ack one");
    chk(nIrq, 1'b0, "level blocks");
    chk(eventIrq, 1'b1, "ack evt");
    srcLevel[3] <= 4'h9;
    ack(4'h9, 4'h6);
    rd(OFS_LEVEL, 32'h0000_0709);
    lvlStack.push_back(int'(rdv[12:8]));
    tick(2);
    chk(nIrq, 1'b0, "nested blocks");
    cl = 5'(lvlStack.pop_back());
    wr(OFS_LEVEL, {19'h0_0000, cl, 3'h0, cl});
    tick(3);
    chk(nIrq, 1'b1, "restored");
    // Mid-run reset brings back the mask and drops forces
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(1);
    chk(sourceMask, '1, "reset mask");
    chk(sourceRequest, '0, "reset force");
    rd(OFS_FORCE_LOW, ZERO);
    rd(OFS_LEVEL, 32'h0000_1F1F);
    tally_and_finish();
  end

endmodule : tb_top

`default_nettype wire
